// ==== src/ncr_common_regs.sv ====
// Purpose: common registers, retry timers, lcp echo timer, interrupt line
// Assumes: byte register port decoded by the serial front end
// Notes:   reads answer one cycle after the read strobe
// Contract
// - retry_count 8 bits, reset 0x08, timeout after count+1
// - tcp timeout closes socket and sets flag
// - arp request resent after each retry_interval
// - arp gives up after retry_count resends
// - tcp segments resent while unacknowledged, bounded
// - tcp wait doubles, capped below 65535 units
// - ppp_auth_type reads agreed method, reset zero
// - ppp_auth_algorithm reads algorithm in use in pppoe mode, zero otherwise
// - lcp echo sent every lcp_echo_interval units of 25 ms
// - lcp_magic_number writable, reset zero, used in lcp
// - chip_revision reads a fixed code
// - reassert delay register 16 bits, reset zero
// - line rises on clear, reasserts after delay+1
// - socket event sets summary bit, masked drives line
// - zeroed socket flags clear summary bit
// - line low while any masked flag set, high for the delay after each clear
// - phy bit 5 reads link state
// - phy bit 3 power-down control, reset 0
// - retry_interval in 100 us units, reset 2000
// - mask bit gates line, not flag
`timescale 1ns/1ps
module ncr_common_regs #(
   parameter int         RTR_CYC  = ncr_pkg::RTR_UNIT_CYC,
   parameter int         LCP_CYC  = ncr_pkg::LCP_UNIT_CYC,
   parameter logic [7:0] REVISION = 8'h5a,  // arbitrary value
   parameter logic [7:0] ECHO_RST = 8'h00
) (
   // clock and reset
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst,
   // register port
   input  wire ncr_pkg::ncr_reg_req_t i_reg,
   output logic [7:0]                 o_reg_rdata,
   // socket engines
   input  wire ncr_pkg::ncr_sock_req_t i_sock,
   input  wire logic [15:0]           i_ppp_auth_type,
   input  wire logic [7:0]            i_ppp_auth_algo,
   input  wire logic                  i_pppoe_mode,
   output logic [7:0]                 o_resend,
   output logic [7:0]                 o_timeout,
   output logic [7:0]                 o_sock_close,
   output logic                       o_lcp_echo,
   output logic [7:0]                 o_lcp_magic,
   // pins
   input  wire logic                  i_phy_link,
   output logic                       o_phy_power_down,
   output logic                       o_int_n
);
   import ncr_pkg::*;
   localparam int NS = NUM_SOCK;

   // ***************
   // register file
   // ***************
   logic [7:0]  retry_count, next_retry_count, sock_mask, next_sock_mask;
   logic [15:0] retry_interval, next_retry_interval, reassert_dly, next_reassert_dly;
   logic [7:0]  lcp_echo_interval, next_lcp_echo_interval, lcp_magic, next_lcp_magic;
   logic        phy_pd, next_phy_pd, link_s1, link_s2, link_s3, link, next_link;
   logic [7:0]  rdata, next_rdata;
   logic [7:0]  summary;
   logic        wr;

   assign wr = i_reg.wr;

   always_comb
   begin
      next_retry_count       = retry_count;
      next_sock_mask         = sock_mask;
      next_retry_interval    = retry_interval;
      next_reassert_dly      = reassert_dly;
      next_lcp_echo_interval = lcp_echo_interval;
      next_lcp_magic         = lcp_magic;
      next_phy_pd            = phy_pd;
      next_link              = (link_s2 == link_s3) ? link_s3 : link;
      if (wr)
      begin
         case (i_reg.addr)
            OFS_SOCK_MASK: next_sock_mask = i_reg.wdata;
            OFS_RTR_HI:    next_retry_interval[15:8] = i_reg.wdata;
            OFS_RTR_LO:    next_retry_interval[7:0] = i_reg.wdata;
            OFS_RETRY_CNT: next_retry_count = i_reg.wdata;
            OFS_LCP_ECHO:  next_lcp_echo_interval = i_reg.wdata;
            OFS_LCP_MAGIC: next_lcp_magic = i_reg.wdata;
            OFS_DLY_HI:    next_reassert_dly[15:8] = i_reg.wdata;
            OFS_DLY_LO:    next_reassert_dly[7:0] = i_reg.wdata;
            OFS_PHY:       next_phy_pd = i_reg.wdata[PHY_PD_BIT];
            default:       next_phy_pd = phy_pd;
         endcase
      end
      next_rdata = RST_BYTE;
      if (i_reg.rd)
      begin
         case (i_reg.addr)
            OFS_SOCK_MASK: next_rdata = sock_mask;
            OFS_RTR_HI:    next_rdata = retry_interval[15:8];
            OFS_RTR_LO:    next_rdata = retry_interval[7:0];
            OFS_RETRY_CNT: next_rdata = retry_count;
            OFS_AUTH_HI:   next_rdata = i_ppp_auth_type[15:8];
            OFS_AUTH_LO:   next_rdata = i_ppp_auth_type[7:0];
            OFS_AUTH_ALGO: next_rdata = i_pppoe_mode ? i_ppp_auth_algo : RST_BYTE;
            OFS_REVISION:  next_rdata = REVISION;
            OFS_LCP_ECHO:  next_rdata = lcp_echo_interval;
            OFS_LCP_MAGIC: next_rdata = lcp_magic;
            OFS_DLY_HI:    next_rdata = reassert_dly[15:8];
            OFS_DLY_LO:    next_rdata = reassert_dly[7:0];
            OFS_SUMMARY:   next_rdata = summary;
            OFS_PHY:
            begin
               next_rdata[PHY_LINK_BIT] = link;
               next_rdata[PHY_PD_BIT]   = phy_pd;
            end
            default:       next_rdata = RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      link_s1 <= i_phy_link;
      link_s2 <= link_s1;
      link_s3 <= link_s2;
      if (i_rst)
      begin
         retry_count       <= RST_RETRY_CNT;
         sock_mask         <= RST_BYTE;
         retry_interval    <= RST_RTR;
         reassert_dly      <= RST_WORD;
         lcp_echo_interval <= ECHO_RST;
         lcp_magic         <= RST_BYTE;
         phy_pd            <= 1'b0;
         link              <= 1'b0;
         rdata             <= RST_BYTE;
      end
      else
      begin
         retry_count       <= next_retry_count;
         sock_mask         <= next_sock_mask;
         retry_interval    <= next_retry_interval;
         reassert_dly      <= next_reassert_dly;
         lcp_echo_interval <= next_lcp_echo_interval;
         lcp_magic         <= next_lcp_magic;
         phy_pd            <= next_phy_pd;
         link              <= next_link;
         rdata             <= next_rdata;
      end
   end

   // ***************
   // time bases
   // ***************
   logic [31:0] rtr_div, next_rtr_div, lcp_div, next_lcp_div;
   logic [7:0]  echo_cnt, next_echo_cnt;
   logic [2:0]  pll_acc, next_pll_acc;
   logic [3:0]  pll_sum;
   logic        rtr_tick, lcp_tick, pll_en, echo, next_echo;

   assign rtr_tick = (rtr_div == 32'(RTR_CYC - 1));
   assign lcp_tick = (lcp_div == 32'(LCP_CYC - 1));
   assign pll_sum  = {1'b0, pll_acc} + PLL_STEP;
   assign pll_en   = pll_sum[3];

   always_comb
   begin
      next_rtr_div  = rtr_tick ? '0 : rtr_div + 32'h1;
      next_lcp_div  = lcp_tick ? '0 : lcp_div + 32'h1;
      next_pll_acc  = pll_sum[2:0];
      next_echo     = 1'b0;
      next_echo_cnt = echo_cnt;
      if (!i_pppoe_mode || lcp_echo_interval == RST_BYTE)
      begin
         next_echo_cnt = RST_BYTE;
      end
      else if (lcp_tick)
      begin
         // one echo every lcp_echo_interval ticks of 25 ms
         if (echo_cnt >= lcp_echo_interval - 8'h1)
         begin
            next_echo_cnt = RST_BYTE;
            next_echo     = 1'b1;
         end
         else
         begin
            next_echo_cnt = echo_cnt + 8'h1;
         end
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         rtr_div  <= '0;
         lcp_div  <= '0;
         pll_acc  <= '0;
         echo_cnt <= RST_BYTE;
         echo     <= 1'b0;
      end
      else
      begin
         rtr_div  <= next_rtr_div;
         lcp_div  <= next_lcp_div;
         pll_acc  <= next_pll_acc;
         echo_cnt <= next_echo_cnt;
         echo     <= next_echo;
      end
   end

   // ***************
   // per-socket retransmission timers
   // ***************
   logic [NS-1:0] resend, timeout, sclose, next_resend, next_timeout, next_sclose;

   for (genvar n = 0; n < NS; n++)
   begin : g_sock
      ncr_tstate_t st, next_st;
      logic [15:0] wcnt, next_wcnt, per, next_per, dbl;
      logic [7:0]  tries, next_tries;

      assign dbl = per[15] ? per : {per[14:0], 1'b0};

      always_comb
      begin
         next_st         = st;
         next_wcnt       = wcnt;
         next_per        = per;
         next_tries      = tries;
         next_resend[n]  = 1'b0;
         next_timeout[n] = 1'b0;
         next_sclose[n]  = 1'b0;
         if (i_sock.ack[n])
         begin
            next_st    = NCR_T_IDLE;
            next_tries = RST_BYTE;
            next_per   = retry_interval;
         end
         else if (i_sock.start[n])
         begin
            next_st    = NCR_T_WAIT;
            next_tries = RST_BYTE;
            next_per   = retry_interval;
            next_wcnt  = retry_interval;
         end
         else
         begin
            case (st)
               NCR_T_IDLE: next_st = NCR_T_IDLE;
               NCR_T_WAIT:
               begin
                  if (rtr_tick && wcnt > 16'h1)
                  begin
                     next_wcnt = wcnt - 16'h1;
                  end
                  else if (rtr_tick)
                  begin
                     if (tries == retry_count)
                     begin
                        next_st         = NCR_T_IDLE;
                        next_timeout[n] = 1'b1;
                        next_sclose[n]  = i_sock.tcp[n];
                     end
                     else
                     begin
                        next_resend[n] = 1'b1;
                        next_tries     = tries + 8'h1;
                        next_per       = i_sock.tcp[n] ? dbl : per;
                        next_wcnt      = i_sock.tcp[n] ? dbl : per;
                     end
                  end
               end
               default: next_st = NCR_T_IDLE;
            endcase
         end
      end

      always_ff @(posedge i_sys_clk)
      begin
         if (i_rst)
         begin
            st    <= NCR_T_IDLE;
            wcnt  <= RST_WORD;
            per   <= RST_RTR;
            tries <= RST_BYTE;
         end
         else
         begin
            st    <= next_st;
            wcnt  <= next_wcnt;
            per   <= next_per;
            tries <= next_tries;
         end
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         resend  <= '0;
         timeout <= '0;
         sclose  <= '0;
      end
      else
      begin
         resend  <= next_resend;
         timeout <= next_timeout;
         sclose  <= next_sclose;
      end
   end

   // ***************
   // summary and interrupt line
   // ***************
   logic [7:0]  next_summary, pend, setv;
   logic [16:0] hold, next_hold;
   logic        int_n, next_int_n, cleared_pend;

   // a set in the same cycle as a clear wins
   assign setv         = i_sock.event_set | timeout;
   assign next_summary = (summary & ~i_sock.flags_zeroed) | setv;
   // mask and summary as they will stand, so a cleared mask drops the line at once
   assign pend         = next_summary & next_sock_mask;
   assign cleared_pend = |(summary & sock_mask & i_sock.flags_zeroed & ~setv);

   always_comb
   begin
      next_int_n = int_n;
      next_hold  = hold;
      if (pend == RST_BYTE)
      begin
         next_int_n = 1'b1;
         next_hold  = '0;
      end
      else if (hold != '0)
      begin
         next_int_n = 1'b1;
         if (pll_en)
         begin
            next_hold = hold - 17'h1;
         end
      end
      else if (cleared_pend && !int_n)
      begin
         next_int_n = 1'b1;
         next_hold  = {1'b0, reassert_dly} + 17'h1;
      end
      else
      begin
         next_int_n = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         summary <= RST_BYTE;
         hold    <= '0;
         int_n   <= 1'b1;
      end
      else
      begin
         summary <= next_summary;
         hold    <= next_hold;
         int_n   <= next_int_n;
      end
   end

   assign o_reg_rdata      = rdata;
   assign o_resend         = resend;
   assign o_timeout        = timeout;
   assign o_sock_close     = sclose;
   assign o_lcp_echo       = echo;
   assign o_lcp_magic      = lcp_magic;
   assign o_phy_power_down = phy_pd;
   assign o_int_n          = int_n;
endmodule

// ==== src/ncr_pkg.sv ====
// Purpose: constants and types of the common register and retry block
// Assumes: 200 MHz system clock, byte-wide register access port
// Notes:   16-bit registers are big-endian, high byte at the lower offset
package ncr_pkg;
   // ***************
   // register offsets
   // ***************
   localparam logic [15:0] OFS_SOCK_MASK = 16'h0016;
   localparam logic [15:0] OFS_RTR_HI    = 16'h0017;
   localparam logic [15:0] OFS_RTR_LO    = 16'h0018;
   localparam logic [15:0] OFS_RETRY_CNT = 16'h0019;
   localparam logic [15:0] OFS_AUTH_HI   = 16'h001c;
   localparam logic [15:0] OFS_AUTH_LO   = 16'h001d;
   localparam logic [15:0] OFS_AUTH_ALGO = 16'h001e;
   localparam logic [15:0] OFS_REVISION  = 16'h001f;
   localparam logic [15:0] OFS_LCP_ECHO  = 16'h0028;
   localparam logic [15:0] OFS_LCP_MAGIC = 16'h0029;
   localparam logic [15:0] OFS_DLY_HI    = 16'h0030;
   localparam logic [15:0] OFS_DLY_LO    = 16'h0031;
   localparam logic [15:0] OFS_SUMMARY   = 16'h0034;
   localparam logic [15:0] OFS_PHY       = 16'h0035;
   // ***************
   // reset values and fields
   // ***************
   localparam logic [7:0]  RST_RETRY_CNT = 8'h08;
   localparam logic [15:0] RST_RTR       = 16'h07d0;
   localparam logic [7:0]  RST_BYTE      = 8'h00;
   localparam logic [15:0] RST_WORD      = 16'h0000;
   localparam logic [15:0] AUTH_PAP      = 16'hc023;
   localparam logic [15:0] AUTH_CHAP     = 16'hc223;
   localparam int          PHY_LINK_BIT  = 5;
   localparam int          PHY_PD_BIT    = 3;
   localparam int          NUM_SOCK      = 8;
   // ***************
   // timing
   // ***************
   localparam int          CLK_PERIOD_PS = 5000;
   localparam int          RTR_UNIT_US   = 100;
   localparam int          LCP_UNIT_MS   = 25;
   localparam int          RTR_UNIT_CYC  = RTR_UNIT_US * 1000000 / CLK_PERIOD_PS;
   localparam int          LCP_UNIT_CYC  = LCP_UNIT_MS * 1000000 / (CLK_PERIOD_PS / 1000);
   // pll enable: 125 of every 200 system edges, phase accumulator 5/8
   localparam logic [3:0]  PLL_STEP      = 4'h5;
   // ***************
   // types
   // ***************
   typedef enum logic [1:0] {
      NCR_T_IDLE = 2'b01,
      NCR_T_WAIT = 2'b10
   } ncr_tstate_t;
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } ncr_reg_req_t;
   typedef struct packed {
      logic [NUM_SOCK-1:0] start;
      logic [NUM_SOCK-1:0] ack;
      logic [NUM_SOCK-1:0] tcp;
      logic [NUM_SOCK-1:0] event_set;
      logic [NUM_SOCK-1:0] flags_zeroed;
   } ncr_sock_req_t;
endpackage

// ==== bench/ncr_assertions.sv ====
// Purpose: port checks of the common register block
// Assumes: one clock domain, synchronous reset
// Notes:   mask and summary are mirrored from port traffic
`timescale 1ns/1ps
module ncr_assertions #(
   parameter int         RTR_CYC  = 4,
   parameter int         LCP_CYC  = 8,
   parameter logic [7:0] REVISION = 8'h00
) (
   // clock and reset
   input wire logic                   i_sys_clk,
   input wire logic                   i_rst,
   // register port
   input wire ncr_pkg::ncr_reg_req_t  i_reg,
   input wire logic [7:0]             o_reg_rdata,
   // sockets
   input wire ncr_pkg::ncr_sock_req_t i_sock,
   input wire logic                   i_pppoe_mode,
   input wire logic [7:0]             o_resend,
   input wire logic [7:0]             o_timeout,
   input wire logic [7:0]             o_sock_close,
   input wire logic                   o_lcp_echo,
   input wire logic [7:0]             o_lcp_magic,
   // pins
   input wire logic                   o_phy_power_down,
   input wire logic                   o_int_n
);
   import ncr_pkg::*;
   logic [7:0] mask, next_mask, summ, next_summ;
   always_comb
   begin
      next_mask = mask;
      if (i_reg.wr && i_reg.addr == OFS_SOCK_MASK)
         next_mask = i_reg.wdata;
      next_summ = (summ & ~i_sock.flags_zeroed) | i_sock.event_set | o_timeout;
   end
   always_ff @(posedge i_sys_clk)
   begin
      mask <= i_rst ? 8'h00 : next_mask;
      summ <= i_rst ? 8'h00 : next_summ;
   end
   default clocking dc @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   a_rev_fixed: assert property (
      i_reg.rd && i_reg.addr == OFS_REVISION |=> o_reg_rdata == REVISION)
      else $error("revision read wrong");
   a_magic_out: assert property (
      i_reg.wr && i_reg.addr == OFS_LCP_MAGIC |=> o_lcp_magic == $past(i_reg.wdata))
      else $error("magic not applied");
   a_pd_write: assert property (
      i_reg.wr && i_reg.addr == OFS_PHY |=> o_phy_power_down == $past(i_reg.wdata[3]))
      else $error("power down bit wrong");
   a_close_tcp: assert property (
      $stable(i_sock.tcp) |-> o_sock_close == (o_timeout & i_sock.tcp))
      else $error("close does not match timeout");
   a_resend_alone: assert property ((o_resend & o_timeout) == 8'h00)
      else $error("resend with timeout");
   a_echo_mode: assert property (!i_pppoe_mode |=> !o_lcp_echo)
      else $error("echo outside pppoe mode");
   a_mask_gate: assert property ((summ & mask) == 8'h00 |-> o_int_n)
      else $error("line low without masked bit");
   a_clear_rise: assert property (
      !o_int_n && (i_sock.flags_zeroed & summ & mask) != 8'h00
      && i_sock.event_set == 8'h00 && o_timeout == 8'h00 |=> o_int_n)
      else $error("line not released on clear");
   c_tcp_close: cover property (o_sock_close != 8'h00);
   c_int_low: cover property (!o_int_n);
   c_reassert: cover property (o_int_n ##1 !o_int_n);
endmodule

bind ncr_common_regs ncr_assertions #(
   .RTR_CYC(RTR_CYC), .LCP_CYC(LCP_CYC), .REVISION(REVISION)) i_ncr_assertions (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg(i_reg), .o_reg_rdata(o_reg_rdata),
   .i_sock(i_sock), .i_pppoe_mode(i_pppoe_mode), .o_resend(o_resend),
   .o_timeout(o_timeout), .o_sock_close(o_sock_close), .o_lcp_echo(o_lcp_echo),
   .o_lcp_magic(o_lcp_magic), .o_phy_power_down(o_phy_power_down), .o_int_n(o_int_n));

// ==== bench/ncr_host_model.sv ====
// Purpose: host side of the byte register port
// Assumes: requests launched on the falling clock edge
// Notes:   an idle port shows inverted stale values
`timescale 1ns/1ps
module ncr_host_model (
   // clock
   input  wire logic             i_sys_clk,
   // register port
   output ncr_pkg::ncr_reg_req_t o_reg
);
   import ncr_pkg::*;
   initial o_reg = '{addr: 16'hffff, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
   // one strobe cycle, then the port idles
   task automatic xfer(input logic [15:0] a, input logic w, input logic [7:0] d);
      @(negedge i_sys_clk);
      o_reg = '{addr: a, wr: w, rd: !w, wdata: d};
      @(negedge i_sys_clk);
      o_reg = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask
endmodule

// ==== bench/net_common_regs_irq_retry_test.sv ====
// Purpose: self-checking bench of the common register block
// Assumes: host model drives the register port
// Notes:   short timer units keep the run brief
`timescale 1ns/1ps
module net_common_regs_irq_retry_test;
   import ncr_pkg::*;
   localparam int         RC  = 4;
   localparam int         LC  = 8;
   localparam logic [7:0] REV = 8'h3c;  // arbitrary value
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   ncr_reg_req_t  reg_q;
   ncr_sock_req_t sock = '0;
   logic [15:0]   auth = 16'h0000;
   logic [7:0]    algo = 8'h00;
   logic          mode = 1'b0;
   logic          link = 1'b0;
   logic [7:0]    rdata, resend, tmo, close, magic, v;
   logic          echo, pd, int_n;
   logic          rd_d = 1'b0;
   int            bad_count = 0;
   int            compares = 0;
   int            seed = 32'h05d40393;
   int            cyc = 0;
   int            last = 0;
   int            ecnt = 0;
   int            g, n, m, k;
   logic [7:0]    rq[$];
   logic [23:0]   eq[$];
   int            gq[$];
   always #2.5 clk = ~clk;
   ncr_common_regs #(.RTR_CYC(RC), .LCP_CYC(LC), .REVISION(REV), .ECHO_RST(8'h00))
   i_ncr_common_regs (
      .i_sys_clk(clk), .i_rst(rst), .i_reg(reg_q), .o_reg_rdata(rdata), .i_sock(sock),
      .i_ppp_auth_type(auth), .i_ppp_auth_algo(algo), .i_pppoe_mode(mode),
      .o_resend(resend), .o_timeout(tmo), .o_sock_close(close), .o_lcp_echo(echo),
      .o_lcp_magic(magic), .i_phy_link(link), .o_phy_power_down(pd), .o_int_n(int_n));
   ncr_host_model i_ncr_host_model (.i_sys_clk(clk), .o_reg(reg_q));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      rq.push_back(e);
      i_ncr_host_model.xfer(a, 1'b0, 8'h00);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      i_ncr_host_model.xfer(a, 1'b1, d);
   endtask
   task automatic kick(input ncr_sock_req_t t);
      @(negedge clk);
      sock = t;
      @(negedge clk);
      sock = '{tcp: t.tcp, default: 8'h00};
   endtask
   task automatic ex(input logic [23:0] e, input int gap);
      eq.push_back(e);
      gq.push_back(gap);
   endtask
   task automatic wrap_up();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // read data and retry events against the oldest note
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (rd_d)
         chk(rdata, rq.pop_front());
      rd_d = reg_q.rd;
      ecnt = ecnt + echo;
      if ((resend | tmo | close) != 8'h00)
      begin
         if (eq.size() == 0)
            chk(32'h1, 32'h0);
         else
         begin
            chk({resend, tmo, close}, eq.pop_front());
            g = gq.pop_front();
            if (g != 0)
               chk(cyc - last, g);
         end
         last = cyc;
      end
   end
   initial
   begin
      link = 1'($random(seed));
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      rd(OFS_SOCK_MASK, RST_BYTE);
      rd(OFS_RTR_HI, RST_RTR[15:8]);
      rd(OFS_RTR_LO, RST_RTR[7:0]);
      rd(OFS_RETRY_CNT, RST_RETRY_CNT);
      rd(OFS_LCP_MAGIC, RST_BYTE);
      rd(OFS_DLY_HI, RST_BYTE);
      rd(OFS_DLY_LO, RST_BYTE);
      rd(OFS_AUTH_HI, RST_BYTE);
      wr(OFS_REVISION, ~REV);
      rd(OFS_REVISION, REV);
      rd(OFS_PHY, {2'b00, link, 5'h00});
      rd(16'h0020, RST_BYTE);
      mode = 1'b1;
      algo = 8'($random(seed));
      for (int i = 0; i < 2; i++)
      begin
         auth = i ? AUTH_CHAP : AUTH_PAP;
         rd(OFS_AUTH_HI, auth[15:8]);
         rd(OFS_AUTH_LO, auth[7:0]);
      end
      rd(OFS_AUTH_ALGO, algo);
      v = 8'($random(seed));
      wr(OFS_LCP_MAGIC, v);
      chk(magic, v);
      wr(OFS_LCP_ECHO, 8'h02);
      k = ecnt;
      repeat (160) @(negedge clk);
      chk((ecnt - k) inside {[160 / (2 * LC) - 1 : 160 / (2 * LC) + 1]}, 1'b1);
      mode = 1'b0;
      wr(OFS_PHY, 8'hff);
      chk(pd, 1'b1);
      link = ~link;
      repeat (8) @(negedge clk);
      rd(OFS_PHY, {2'b00, link, 2'b01, 3'b000});
      wr(OFS_PHY, 8'h00);
      chk(pd, 1'b0);
      wr(OFS_RTR_HI, 8'h00);
      wr(OFS_RTR_LO, 8'h01);
      wr(OFS_RETRY_CNT, 8'h02);
      n = $unsigned($random(seed)) % 8;
      m = (n + 1) % 8;
      ex({8'h01 << n, 16'h0000}, 0);
      ex({8'h01 << n, 16'h0000}, RC);
      ex({8'h00, 8'h01 << n, 8'h00}, RC);
      kick('{start: 8'h01 << n, default: 8'h00});
      for (int i = 0; i < 400 && eq.size() != 0; i++)
         @(negedge clk);
      ex({8'h01 << m, 16'h0000}, 0);
      ex({8'h01 << m, 16'h0000}, 2 * RC);
      ex({8'h00, 8'h01 << m, 8'h01 << m}, 4 * RC);
      kick('{start: 8'h01 << m, tcp: 8'h01 << m, default: 8'h00});
      for (int i = 0; i < 400 && eq.size() != 0; i++)
         @(negedge clk);
      chk(eq.size(), 0);
      rd(OFS_SUMMARY, (8'h01 << n) | (8'h01 << m));
      wr(OFS_RTR_LO, 8'h03);
      kick('{start: 8'h01 << n, default: 8'h00});
      kick('{ack: 8'h01 << n, default: 8'h00});
      repeat (100) @(negedge clk);
      kick('{flags_zeroed: 8'hff, default: 8'h00});
      wr(OFS_SOCK_MASK, 8'h03);
      wr(OFS_DLY_LO, 8'h0f);
      chk(int_n, 1'b1);
      kick('{event_set: 8'h01, default: 8'h00});
      chk(int_n, 1'b0);
      kick('{event_set: 8'h06, default: 8'h00});
      rd(OFS_SUMMARY, 8'h07);
      kick('{flags_zeroed: 8'h01, default: 8'h00});
      for (k = 0; k < 60 && int_n === 1'b1; k++)
         @(negedge clk);
      chk(k >= 24 && k <= 28, 1'b1);
      kick('{flags_zeroed: 8'h02, default: 8'h00});
      repeat (40) @(negedge clk);
      chk(int_n, 1'b1);
      wr(OFS_SUMMARY, 8'h00);
      rd(OFS_SUMMARY, 8'h04);
      repeat (4) @(negedge clk);
      wrap_up();
   end
   initial
   begin
      #50us;
      bad_count++;
      wrap_up();
   end
endmodule
